/* File: src/vis_params.svh */
`ifndef VIS_PARAMS_SVH
`define VIS_PARAMS_SVH

// ----------------------------------------------------------------------
// device pages and register addresses
// ----------------------------------------------------------------------
`define VIS_PAGE_VIDEO      8'h07
`define VIS_PAGE_PHY        8'h08
`define VIS_ADDR_PCHECK     9'h001
`define VIS_ADDR_HOTPLUG    9'h080
`define VIS_ADDR_ARG        9'h082
`define VIS_ADDR_CODE       9'h083
`define VIS_ADDR_TRIG       9'h084
`define VIS_ADDR_RANGE      9'h085
`define VIS_ADDR_DONE       9'h100
`define VIS_ADDR_UPPHY      9'h139

// ----------------------------------------------------------------------
// values written during startup
// ----------------------------------------------------------------------
`define VIS_PCHECK_OFF      8'h00
`define VIS_TRIG_GO         8'h05
`define VIS_HOTPLUG_ON      8'h01
`define VIS_ARG_MASK        8'h68
`define VIS_CODE_MASK       8'h06
`define VIS_ARG_PUMP        8'h30
`define VIS_CODE_PUMP       8'hBE
`define VIS_ARG_OSC         8'h0F
`define VIS_CODE_OSC        8'hBF
`define VIS_ARG_BGAP        8'h02
`define VIS_CODE_BGAP       8'hC6
`define VIS_DONE_BIT        0

// ----------------------------------------------------------------------
// upstream phy control fields
// ----------------------------------------------------------------------
`define VIS_PHY_CALIB_BIT   7
`define VIS_PHY_TRIG_BIT    6
`define VIS_PHY_DET_BIT     5
`define VIS_PHY_SEL_HI      4
`define VIS_PHY_SEL_LO      3
`define VIS_PHY_OFFSET_BIT  0
`define VIS_PHY_DEV_RESET   8'h58
`define VIS_PHY_HOST_VALUE  8'h59

// ----------------------------------------------------------------------
// sequence table layout
// ----------------------------------------------------------------------
`define VIS_STEP_RANGE      5'h00
`define VIS_STEP_PCHECK     5'h01
`define VIS_STEP_CMD_FIRST  5'h02
`define VIS_STEP_CMD_LAST   5'h11
`define VIS_STEP_HOTPLUG    5'h12
`define VIS_STEP_PHY        5'h13
`define VIS_STEP_UPEN       5'h14

// ----------------------------------------------------------------------
// apb register map and reset values
// ----------------------------------------------------------------------
`define VIS_REG_CTRL        12'h000
`define VIS_REG_STATUS      12'h004
`define VIS_REG_CFG         12'h008
`define VIS_REG_UPEN        12'h00C
`define VIS_CFG_RESET       32'h0001_5900
`define VIS_UPEN_RESET      32'h0000_0000
`define VIS_CTRL_START_BIT  0
`define VIS_CFG_PHY_EN_BIT  16
`define VIS_UPEN_EN_BIT     24

`endif

/* File: src/vis_pkg.sv */
package vis_pkg;

   // operation of one sequence step
   typedef enum logic [2:0] {
      OP_WR_CONST,
      OP_WR_RANGE,
      OP_WR_PHY,
      OP_WR_UPEN,
      OP_POLL,
      OP_END
   } vis_op_t;

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_LOAD,
      ST_ACCESS
   } vis_state_t;

   // apb register selector
   typedef enum logic [2:0] {
      SEL_CTRL,
      SEL_STATUS,
      SEL_CFG,
      SEL_UPEN,
      SEL_NONE
   } vis_sel_t;

endpackage

/* File: src/vis_step_rom.sv */
`timescale 1ns/1ps
`include "vis_params.svh"

module vis_step_rom import vis_pkg::*; (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [4:0] step,
   output vis_op_t         op_q,
   output logic      [7:0] page_q,
   output logic      [8:0] addr_q,
   output logic      [7:0] data_q
);

   vis_op_t    op_d;
   logic [7:0] page_d;
   logic [8:0] addr_d;
   logic [7:0] data_d;
   logic [4:0] rel;

   // ----------------------------------------------------------------------
   // analog command tables
   // ----------------------------------------------------------------------
   function automatic logic [7:0] cmd_arg(input logic [1:0] n);
      case (n)
         2'h0:    cmd_arg = `VIS_ARG_MASK;
         2'h1:    cmd_arg = `VIS_ARG_PUMP;
         2'h2:    cmd_arg = `VIS_ARG_OSC;
         default: cmd_arg = `VIS_ARG_BGAP;
      endcase
   endfunction

   function automatic logic [7:0] cmd_code(input logic [1:0] n);
      case (n)
         2'h0:    cmd_code = `VIS_CODE_MASK;
         2'h1:    cmd_code = `VIS_CODE_PUMP;
         2'h2:    cmd_code = `VIS_CODE_OSC;
         default: cmd_code = `VIS_CODE_BGAP;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // step lookup: each command is argument, code, trigger, done poll
   // ----------------------------------------------------------------------
   always_comb begin
      rel    = step - `VIS_STEP_CMD_FIRST;
      op_d   = OP_WR_CONST;
      page_d = `VIS_PAGE_VIDEO;
      addr_d = `VIS_ADDR_RANGE;
      data_d = 8'h00;
      if (step == `VIS_STEP_RANGE) begin
         op_d = OP_WR_RANGE;
      end else if (step == `VIS_STEP_PCHECK) begin
         addr_d = `VIS_ADDR_PCHECK;
         data_d = `VIS_PCHECK_OFF;
      end else if (step <= `VIS_STEP_CMD_LAST) begin
         case (rel[1:0])
            2'h0: begin
               addr_d = `VIS_ADDR_ARG;
               data_d = cmd_arg(rel[3:2]);
            end
            2'h1: begin
               addr_d = `VIS_ADDR_CODE;
               data_d = cmd_code(rel[3:2]);
            end
            2'h2: begin
               addr_d = `VIS_ADDR_TRIG;
               data_d = `VIS_TRIG_GO;
            end
            default: begin
               op_d   = OP_POLL;
               addr_d = `VIS_ADDR_DONE;
            end
         endcase
      end else if (step == `VIS_STEP_HOTPLUG) begin
         addr_d = `VIS_ADDR_HOTPLUG;
         data_d = `VIS_HOTPLUG_ON;
      end else if (step == `VIS_STEP_PHY) begin
         op_d   = OP_WR_PHY;
         page_d = `VIS_PAGE_PHY;
         addr_d = `VIS_ADDR_UPPHY;
      end else if (step == `VIS_STEP_UPEN) begin
         op_d = OP_WR_UPEN;
      end else begin
         op_d = OP_END;
      end
   end

   // registered read data
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         op_q   <= OP_END;
         page_q <= 8'h00;
         addr_q <= 9'h000;
         data_q <= 8'h00;
      end else begin
         op_q   <= op_d;
         page_q <= page_d;
         addr_q <= addr_d;
         data_q <= data_d;
      end
   end

endmodule // vis_step_rom

/* File: src/vis_startup_ctrl.sv */
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "vis_params.svh"

// Notes on behaviour
// - first write the pixel-clock range code to page 0x07 address 0x085
// - then write zero to address 0x001 to switch the parameter check off
// - each command writes argument 0x082, code 0x083, then 0x05 to 0x084
// - after each command read 0x100 until bit 0 is one; reads clear it
// - second command: argument 0x30, code 0xBE, charge pump
// - third command: argument 0x0F, code 0xBF, oscillator gain
// - fourth command: argument 0x02, code 0xC6, band-gap reference
// - then write 0x01 to address 0x080 to raise hot-plug indication
// - set the upstream enable bit in the phy power-down registers; written only when UPEN bit 24 is set, which reset clears
// - offset compensation bit 0 of 0x139 should be set to one

module vis_startup_ctrl import vis_pkg::*; (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   output logic             dev_req,
   output logic             dev_we,
   output logic      [7:0]  dev_page,
   output logic      [8:0]  dev_addr,
   output logic      [7:0]  dev_wdata,
   input  wire logic        dev_ack,
   input  wire logic [7:0]  dev_rdata
);

   // ----------------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   vis_state_t  state_q,  state_d;
   logic [4:0]  step_q,   step_d;
   logic        done_q,   done_d;
   logic [15:0] polls_q,  polls_d;
   logic        we_q,     we_d;
   logic [7:0]  page_q,   page_d;
   logic [8:0]  addr_q,   addr_d;
   logic [7:0]  wdata_q,  wdata_d;
   logic [31:0] cfg_q,    cfg_d;
   logic [31:0] upen_q,   upen_d;
   logic [31:0] rdata_q,  rdata_d;
   vis_op_t     rom_op;
   logic [7:0]  rom_page;
   logic [8:0]  rom_addr;
   logic [7:0]  rom_data;
   logic        setup_ph;
   logic        access_ph;
   logic        start_wr;
   logic [7:0]  phy_value;
   vis_sel_t    sel;

   // ----------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------
   function automatic vis_sel_t reg_sel(input logic [11:0] a);
      case (a)
         `VIS_REG_CTRL:   reg_sel = SEL_CTRL;
         `VIS_REG_STATUS: reg_sel = SEL_STATUS;
         `VIS_REG_CFG:    reg_sel = SEL_CFG;
         `VIS_REG_UPEN:   reg_sel = SEL_UPEN;
         default:         reg_sel = SEL_NONE;
      endcase
   endfunction

   // zero-wait slave, read data registered during setup
   assign sel       = reg_sel(paddr);
   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign pready    = 1'b1;
   assign pslverr   = access_ph && (sel == SEL_NONE);
   assign prdata    = rdata_q;
   assign start_wr  = access_ph && pwrite && (sel == SEL_CTRL) &&
                      pwdata[`VIS_CTRL_START_BIT];

   // host value for the upstream phy register, unused bits kept zero
   assign phy_value = {cfg_q[15:11], 2'b00, cfg_q[8]};

   // ----------------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------------
   always_comb begin
      cfg_d   = cfg_q;
      upen_d  = upen_q;
      rdata_d = rdata_q;
      if (access_ph && pwrite && sel == SEL_CFG) begin
         cfg_d = pwdata & 32'h0001_FF03;
      end
      if (access_ph && pwrite && sel == SEL_UPEN) begin
         upen_d = pwdata & 32'h01FF_FFFF;
      end
      if (setup_ph && !pwrite) begin
         case (sel)
            SEL_STATUS: rdata_d = {polls_q, 3'h0, step_q, 6'h00, done_q,
                                   state_q != ST_IDLE};
            SEL_CFG:    rdata_d = cfg_q;
            SEL_UPEN:   rdata_d = upen_q;
            default:    rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q   <= `VIS_CFG_RESET;
         upen_q  <= `VIS_UPEN_RESET;
         rdata_q <= 32'h0000_0000;
      end else begin
         cfg_q   <= cfg_d;
         upen_q  <= upen_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------------
   // sequence table
   // ----------------------------------------------------------------------
   vis_step_rom u_rom (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .step   (step_q),
      .op_q   (rom_op),
      .page_q (rom_page),
      .addr_q (rom_addr),
      .data_q (rom_data)
   );

   // ----------------------------------------------------------------------
   // startup sequencer
   // ----------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      step_d  = step_q;
      done_d  = done_q;
      polls_d = polls_q;
      we_d    = we_q;
      page_d  = page_q;
      addr_d  = addr_q;
      wdata_d = wdata_q;
      case (state_q)
         ST_IDLE: begin
            if (start_wr) begin
               step_d  = `VIS_STEP_RANGE;
               done_d  = 1'b0;
               polls_d = 16'h0000;
               state_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_d = ST_LOAD;
         end
         ST_LOAD: begin
            page_d  = rom_page;
            addr_d  = rom_addr;
            we_d    = (rom_op != OP_POLL);
            case (rom_op)
               OP_WR_RANGE: wdata_d = {6'h00, cfg_q[1:0]};
               OP_WR_PHY:   wdata_d = phy_value;
               OP_WR_UPEN: begin
                  page_d  = upen_q[15:8];
                  addr_d  = upen_q[8:0];
                  wdata_d = upen_q[23:16];
               end
               OP_POLL:     wdata_d = 8'h00;
               default:     wdata_d = rom_data;
            endcase
            if (rom_op == OP_END) begin
               done_d  = 1'b1;
               state_d = ST_IDLE;
            end else if ((rom_op == OP_WR_PHY && !cfg_q[`VIS_CFG_PHY_EN_BIT]) ||
                         (rom_op == OP_WR_UPEN && !upen_q[`VIS_UPEN_EN_BIT])) begin
               step_d  = step_q + 5'h01;
               state_d = ST_FETCH;
            end else begin
               state_d = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            if (dev_ack) begin
               state_d = ST_FETCH;
               if (!we_q && !dev_rdata[`VIS_DONE_BIT]) begin
                  if (polls_q != 16'hFFFF) begin
                     polls_d = polls_q + 16'h0001;
                  end
               end else begin
                  step_d = step_q + 5'h01;
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         step_q  <= 5'h00;
         done_q  <= 1'b0;
         polls_q <= 16'h0000;
         we_q    <= 1'b0;
         page_q  <= 8'h00;
         addr_q  <= 9'h000;
         wdata_q <= 8'h00;
      end else begin
         state_q <= state_d;
         step_q  <= step_d;
         done_q  <= done_d;
         polls_q <= polls_d;
         we_q    <= we_d;
         page_q  <= page_d;
         addr_q  <= addr_d;
         wdata_q <= wdata_d;
      end
   end

   // device port, request held until acknowledged
   assign dev_req   = (state_q == ST_ACCESS);
   assign dev_we    = we_q;
   assign dev_page  = page_q;
   assign dev_addr  = addr_q;
   assign dev_wdata = wdata_q;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   logic [7:0] last_arg_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         last_arg_q <= 8'h00;
      end else if (dev_req && dev_ack && dev_we && dev_addr == `VIS_ADDR_ARG) begin
         last_arg_q <= dev_wdata;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_range_first: assert property (
      state_q == ST_LOAD && step_q == `VIS_STEP_RANGE |=> dev_addr == `VIS_ADDR_RANGE
      && dev_we && dev_page == `VIS_PAGE_VIDEO && dev_wdata == {6'h00, cfg_q[1:0]})
      else $error("range write wrong");
   a_pcheck_off: assert property (
      state_q == ST_LOAD && step_q == `VIS_STEP_PCHECK |=> dev_req && dev_we
      && dev_addr == `VIS_ADDR_PCHECK && dev_wdata == `VIS_PCHECK_OFF)
      else $error("parameter check write wrong");
   a_trig_value: assert property (
      dev_req && dev_we && dev_addr == `VIS_ADDR_TRIG |-> dev_wdata == `VIS_TRIG_GO)
      else $error("trigger value wrong");
   a_cmd_pairing: assert property (
      dev_req && dev_we && dev_addr == `VIS_ADDR_CODE |->
      (dev_wdata == `VIS_CODE_MASK && last_arg_q == `VIS_ARG_MASK) ||
      (dev_wdata == `VIS_CODE_PUMP && last_arg_q == `VIS_ARG_PUMP) ||
      (dev_wdata == `VIS_CODE_OSC && last_arg_q == `VIS_ARG_OSC) ||
      (dev_wdata == `VIS_CODE_BGAP && last_arg_q == `VIS_ARG_BGAP))
      else $error("command code does not match argument");
   a_poll_retry: assert property (
      dev_req && dev_ack && !dev_we && !dev_rdata[`VIS_DONE_BIT] |=>
      $stable(step_q) ##2 dev_req && !dev_we && dev_addr == `VIS_ADDR_DONE)
      else $error("failed poll not repeated");
   a_poll_advance: assert property (
      dev_req && dev_ack && !dev_we && dev_rdata[`VIS_DONE_BIT] |=>
      step_q == $past(step_q) + 5'h01)
      else $error("done poll did not advance");
   a_req_hold: assert property (
      dev_req && !dev_ack |=> dev_req && $stable(dev_addr) && $stable(dev_wdata)
      && $stable(dev_we))
      else $error("request dropped before ack");
   a_hotplug_value: assert property (
      dev_req && dev_we && dev_page == `VIS_PAGE_VIDEO && dev_addr == `VIS_ADDR_HOTPLUG
      |-> dev_wdata == `VIS_HOTPLUG_ON)
      else $error("hot-plug value wrong");
   a_phy_unused: assert property (
      dev_req && dev_we && dev_page == `VIS_PAGE_PHY && dev_addr == `VIS_ADDR_UPPHY
      |-> dev_wdata[2:1] == 2'b00 && dev_wdata == phy_value)
      else $error("phy write wrong");
   a_upen_write: assert property (
      state_q == ST_LOAD && rom_op == OP_WR_UPEN && upen_q[`VIS_UPEN_EN_BIT] |=>
      dev_req && dev_wdata == upen_q[23:16] && dev_addr == upen_q[8:0])
      else $error("upstream enable write wrong");

   c_start:     cover property (state_q == ST_IDLE && start_wr);
   c_poll_miss: cover property (dev_req && dev_ack && !dev_we && !dev_rdata[0]);
   c_seq_done:  cover property ($rose(done_q));

endmodule // vis_startup_ctrl

/* File: verification/vis_dev_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// device side model: answers requests, keeps the done flag and phy byte
// ----------------------------------------------------------------------
module vis_dev_model import vis_pkg::*; (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       dev_req,
   input  wire logic       dev_we,
   input  wire logic [7:0] dev_page,
   input  wire logic [8:0] dev_addr,
   input  wire logic [7:0] dev_wdata,
   input  wire logic [3:0] ack_wait,
   input  wire logic [3:0] fails,
   output logic            dev_ack,
   output logic      [7:0] dev_rdata
);
   logic [31:0] log_q[$];
   logic [3:0]  wait_q;
   logic [3:0]  miss_q;
   logic [7:0]  phy_q;
   logic        clr_q;

   // ack after ack_wait cycles; log every access taken
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dev_ack   <= 1'b0;
         dev_rdata <= 8'h00;
         wait_q    <= 4'h0;
         miss_q    <= 4'h0;
         clr_q     <= 1'b0;
         phy_q     <= 8'h58;
      end else begin
         dev_ack   <= 1'b0;
         dev_rdata <= ~dev_rdata; // inverted every cycle except when answering a read of 0x100 or 0x139
         clr_q     <= 1'b0;
         if (clr_q) phy_q[6] <= 1'b0;
         if (dev_req && !dev_ack) begin
            if (wait_q < ack_wait) begin
               wait_q <= wait_q + 4'h1;
            end else begin
               wait_q  <= 4'h0;
               dev_ack <= 1'b1;
               log_q.push_back({6'h00, dev_we, dev_page, dev_addr,
                                dev_we ? dev_wdata : 8'h00});
               if (dev_we && dev_page == 8'h08 && dev_addr == 9'h139) begin
                  phy_q <= {dev_wdata[7:3], 2'b00, dev_wdata[0]};
                  clr_q <= 1'b1;
               end
               if (dev_we && dev_addr == 9'h084 && dev_wdata == 8'h05) begin
                  miss_q <= 4'h0;
               end
               if (!dev_we && dev_addr == 9'h100) begin
                  // done shows after fails polls, and the read clears it
                  dev_rdata <= {7'h00, miss_q == fails};
                  miss_q    <= (miss_q == fails) ? 4'h0 : miss_q + 4'h1;
               end else if (!dev_we && dev_addr == 9'h139) begin
                  dev_rdata <= phy_q;
               end
            end
         end
      end
   end
endmodule // vis_dev_model

/* File: verification/test_video_input_startup_phy_config.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// bench: apb host driving the startup controller against the model
// ----------------------------------------------------------------------
module test_video_input_startup_phy_config;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        pready, pslverr, dev_req, dev_we, dev_ack;
   logic [31:0] prdata;
   logic [7:0]  dev_page, dev_wdata, dev_rdata;
   logic [8:0]  dev_addr;
   logic [3:0]  ack_wait = 4'h0;
   logic [3:0]  fails = 4'h0;
   logic [31:0] exp_q[$];
   logic [31:0] rd;
   logic        err;
   int          errors = 0;
   int          n_checks = 0;

   always #2.5 mclk = ~mclk;

   vis_startup_ctrl u_vis_startup_ctrl (.mclk(mclk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .dev_req(dev_req), .dev_we(dev_we),
      .dev_page(dev_page), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
      .dev_rdata(dev_rdata));

   vis_dev_model u_vis_dev_model (.mclk(mclk), .reset_n(reset_n), .dev_req(dev_req),
      .dev_we(dev_we), .dev_page(dev_page), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
      .ack_wait(ack_wait), .fails(fails), .dev_ack(dev_ack), .dev_rdata(dev_rdata));

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin errors++; test_done(); end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic push(input logic we, input logic [7:0] pg, input logic [8:0] ad,
                       input logic [7:0] d);
      exp_q.push_back({6'h00, we, pg, ad, d});
   endtask

   // start a sequence, poke start while busy, wait for done, compare the log
   task automatic run_seq(input logic [1:0] rng, input logic [7:0] phy, input logic phy_on,
                          input logic up_on, input logic [3:0] aw, input logic [3:0] nf,
                          input logic cnt_chk);
      logic [7:0] args[4];
      logic [7:0] codes[4];
      int i;
      args  = '{8'h68, 8'h30, 8'h0F, 8'h02};
      codes = '{8'h06, 8'hBE, 8'hBF, 8'hC6};
      ack_wait <= aw; fails <= nf;
      exp_q.delete();
      u_vis_dev_model.log_q.delete();
      push(1'b1, 8'h07, 9'h085, {6'h00, rng});
      push(1'b1, 8'h07, 9'h001, 8'h00);
      for (i = 0; i < 4; i++) begin
         push(1'b1, 8'h07, 9'h082, args[i]);
         push(1'b1, 8'h07, 9'h083, codes[i]);
         push(1'b1, 8'h07, 9'h084, 8'h05);
         repeat (nf + 1) push(1'b0, 8'h07, 9'h100, 8'h00);
      end
      push(1'b1, 8'h07, 9'h080, 8'h01);
      if (phy_on) push(1'b1, 8'h08, 9'h139, phy & 8'hF9);
      if (up_on) push(1'b1, 8'h08, 9'h0A0, 8'h01);
      apb(1'b1, 12'h008, {15'h0, phy_on, phy, 6'h00, rng});
      apb(1'b1, 12'h00C, {7'h00, up_on, 8'h01, 8'h08, 8'hA0});
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      check({30'h0, rd[1:0]}, 32'h1);
      apb(1'b1, 12'h000, 32'h1);
      for (i = 0; i < 400; i++) begin
         apb(1'b0, 12'h004, 32'h0);
         if (rd[1] === 1'b1) break;
      end
      if (i == 400) begin errors++; test_done(); end
      check({30'h0, rd[1:0]}, 32'h2);
      check({27'h0, rd[12:8]}, 32'h15);
      if (cnt_chk) check({16'h0, rd[31:16]}, 32'(4 * nf));
      check(u_vis_dev_model.log_q.size(), exp_q.size());
      for (i = 0; i < exp_q.size() && i < u_vis_dev_model.log_q.size(); i++)
         check(u_vis_dev_model.log_q[i], exp_q[i]);
   endtask

   task automatic t_reset();
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h0001_5900);
      apb(1'b0, 12'h00C, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      check({err, rd[30:0]}, 32'h8000_0000);
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h0001_5900);
      check({24'h0, u_vis_dev_model.phy_q}, 32'h58);
      $display("reset values done");
   endtask

   task automatic t_full();
      run_seq(2'd0, 8'h59, 1'b1, 1'b1, 4'd3, 4'd2, 1'b1);
      $display("full sequence slow device done");
   endtask

   task automatic t_ranges();
      run_seq(2'd1, 8'hFF, 1'b1, 1'b0, 4'd0, 4'd0, 1'b0);
      run_seq(2'd2, 8'h59, 1'b0, 1'b0, 4'd1, 4'd1, 1'b0);
      $display("ranges and skipped steps done");
   endtask

   initial begin
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset();
      t_full();
      t_ranges();
      test_done();
   end
endmodule // test_video_input_startup_phy_config
